// >>> nv_access_pkg.sv
// Constants and carrier types for the data EEPROM access unit.
// Assumes a single 50 MHz system clock and an SFR bus driven by the CPU.
package nv_access_pkg;

  localparam logic [8:0] LVR_DISABLE_KEY_ADDR = 9'h109;
  localparam logic [8:0] TABLE_READ_TRIGGER_ADDR = 9'h18c;
  localparam logic [8:0] NV_WRITE_CONTROL_ADDR = 9'h18d;
  localparam logic [8:0] NV_ACCESS_KEY_ADDR = 9'h18e;
  localparam logic [8:0] NV_WRITE_DATA_ADDR = 9'h18f;

  localparam logic [7:0] ACCESS_KEY_VALUE = 8'he2;
  localparam logic [7:0] LVR_OFF_VALUE = 8'h37;
  localparam logic [7:0] CMD_READ_LOW = 8'h01;
  localparam logic [7:0] CMD_READ_HIGH = 8'h02;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  localparam int NV_DEPTH = 128;
  localparam int NV_ADDR_W = 7;
  localparam int TO_FLAG_BIT = 2;

  localparam int CLK_HZ = 50_000_000;
  localparam int WDOG_1_US = 1600;
  localparam int WDOG_2_US = 6400;
  localparam int WDOG_3_US = 12800;
  localparam int WDOG_1_CYC = WDOG_1_US * (CLK_HZ / 1_000_000);
  localparam int WDOG_2_CYC = WDOG_2_US * (CLK_HZ / 1_000_000);
  localparam int WDOG_3_CYC = WDOG_3_US * (CLK_HZ / 1_000_000);
  localparam int WDOG_CNT_W = 20;

  // Programming time of the array, in cycles
  localparam int PROG_CYC_DEFAULT = 100000;

  typedef enum logic [1:0]
  {
    WD_OFF = 2'b00,
    WD_SHORT = 2'b01,
    WD_MID = 2'b10,
    WD_LONG = 2'b11
  } watchdog_sel_t;

  typedef enum logic [0:0]
  {
    ST_IDLE = 1'b0,
    ST_PROG = 1'b1
  } prog_state_t;

  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

endpackage

// >>> data_eeprom_access_unit.sv
// Data EEPROM access unit: key, table read, byte write and write watchdog.
// Assumes the CPU presents one SFR access per cycle and supplies ROM words.
//
// Summary of operation
// - A 128-byte data space is kept, each byte read and written alone.
// - Writing E2h to the access key enables access, any other value disables it.
// - While enabled, a low-byte table read returns the EEPROM byte instead of ROM.
// - With access enabled and no write running, a write-data write programs that byte at the pointer.
// - The watchdog field picks off, 1.6 ms, 6.4 ms or 12.8 ms.
// - A write running past the selected time sets read-only bit 2 of control.
// - The time-out flag is cleared by hardware while the field is zero.
// - Command 01h reads the low byte, 02h the high byte of the pointed word.
// - After a command, reading the table-read register gives the fetched byte.
// - With key E2h and a low-byte command, the read gives the EEPROM byte.
// - The disable key is 8-bit write-only, zero at reset, 37h forces it off.
// - The table pointer is the high pointer byte above the low one.
`timescale 1ns/1ns
module data_eeprom_access_unit #(
  parameter int PROG_CYC = nv_access_pkg::PROG_CYC_DEFAULT,
  parameter int WDOG_1 = nv_access_pkg::WDOG_1_CYC,
  parameter int WDOG_2 = nv_access_pkg::WDOG_2_CYC,
  parameter int WDOG_3 = nv_access_pkg::WDOG_3_CYC
) (
  input wire logic clk_in,                       // System clock
  input wire logic rst_n_in,                     // Async reset, low
  input wire nv_access_pkg::sfr_req_t sfr_in,    // SFR access
  input wire logic [7:0] pointer_low_in,         // Pointer low byte
  input wire logic [7:0] pointer_high_in,        // Pointer high byte
  input wire logic [15:0] rom_word_in,           // ROM word at rom_addr_out
  output logic [15:0] rom_addr_out,              // Table pointer to ROM
  output logic [7:0] sfr_rdata_out,              // SFR read data
  output logic low_voltage_reset_off_out,        // Forces LOW_VOLTAGE_RESET off
  output logic busy_out                          // Programming in progress
);

  logic [7:0] mem [nv_access_pkg::NV_DEPTH];
  logic [7:0] key_reg;
  logic lvr_off_reg;
  logic [7:0] tab_reg;
  logic [1:0] wd_sel_reg;
  logic to_flag_reg;
  logic [nv_access_pkg::WDOG_CNT_W-1:0] wd_cnt_reg;
  logic [nv_access_pkg::WDOG_CNT_W-1:0] prog_cnt_reg;
  logic [nv_access_pkg::NV_ADDR_W-1:0] prog_addr_reg;
  logic [7:0] prog_data_reg;
  logic [15:0] rom_addr_reg;
  logic [7:0] rdata_reg;
  nv_access_pkg::prog_state_t state_reg;
  nv_access_pkg::prog_state_t state_next;
  logic busy_reg;

  function automatic logic hit(input nv_access_pkg::sfr_req_t r, input logic [8:0] a);
    hit = r.addr == a;
  endfunction

  // Both counters step through here
  function automatic logic [nv_access_pkg::WDOG_CNT_W-1:0] bump(
    input logic [nv_access_pkg::WDOG_CNT_W-1:0] v
  );
    bump = v + nv_access_pkg::WDOG_CNT_W'(1);
  endfunction

  wire logic wr_key = sfr_in.wr && hit(sfr_in, nv_access_pkg::NV_ACCESS_KEY_ADDR);
  wire logic wr_lvr = sfr_in.wr && hit(sfr_in, nv_access_pkg::LVR_DISABLE_KEY_ADDR);
  wire logic wr_tab = sfr_in.wr && hit(sfr_in, nv_access_pkg::TABLE_READ_TRIGGER_ADDR);
  wire logic wr_ctl = sfr_in.wr && hit(sfr_in, nv_access_pkg::NV_WRITE_CONTROL_ADDR);
  wire logic wr_dat = sfr_in.wr && hit(sfr_in, nv_access_pkg::NV_WRITE_DATA_ADDR);
  wire logic access_en = key_reg == nv_access_pkg::ACCESS_KEY_VALUE;
  wire logic idle = state_reg == nv_access_pkg::ST_IDLE;
  wire logic [15:0] table_pointer = {pointer_high_in, pointer_low_in};
  // EEPROM ignores the high byte and bit 7
  wire logic [nv_access_pkg::NV_ADDR_W-1:0] nv_addr =
    pointer_low_in[nv_access_pkg::NV_ADDR_W-1:0];
  wire logic launch = wr_dat && access_en && idle;
  wire logic prog_done = !idle &&
    (prog_cnt_reg == nv_access_pkg::WDOG_CNT_W'(PROG_CYC - 1));

  logic [nv_access_pkg::WDOG_CNT_W-1:0] wd_limit;
  always_comb
  begin
    case (nv_access_pkg::watchdog_sel_t'(wd_sel_reg))
      nv_access_pkg::WD_SHORT: wd_limit = nv_access_pkg::WDOG_CNT_W'(WDOG_1);
      nv_access_pkg::WD_MID: wd_limit = nv_access_pkg::WDOG_CNT_W'(WDOG_2);
      nv_access_pkg::WD_LONG: wd_limit = nv_access_pkg::WDOG_CNT_W'(WDOG_3);
      default: wd_limit = '0;
    endcase
  end

  wire logic wd_on = wd_sel_reg != 2'h0;
  wire logic wd_expire = !idle && wd_on && !prog_done && (wd_cnt_reg == wd_limit - 1'b1);

  // Launch on a write, idle at completion
  always_comb
  begin
    case (state_reg)
      nv_access_pkg::ST_IDLE:
        state_next = launch ? nv_access_pkg::ST_PROG : nv_access_pkg::ST_IDLE;
      nv_access_pkg::ST_PROG:
        state_next = prog_done ? nv_access_pkg::ST_IDLE : nv_access_pkg::ST_PROG;
      default:
        state_next = nv_access_pkg::ST_IDLE;
    endcase
  end

  // Counters freeze outside a write so no late expiry
  wire logic hold_cnt = idle || prog_done;
  wire logic [nv_access_pkg::WDOG_CNT_W-1:0] prog_cnt_next =
    launch ? '0 : hold_cnt ? prog_cnt_reg : bump(prog_cnt_reg);
  wire logic [nv_access_pkg::WDOG_CNT_W-1:0] wd_cnt_next =
    launch ? '0 : (hold_cnt || wd_cnt_reg == wd_limit) ? wd_cnt_reg : bump(wd_cnt_reg);
  wire logic to_flag_next = wd_on && (wd_expire || to_flag_reg);

  // EEPROM on low command when enabled
  wire logic [7:0] tab_fetch =
    (sfr_in.wdata == nv_access_pkg::CMD_READ_LOW && access_en) ? mem[nv_addr] :
    (sfr_in.wdata == nv_access_pkg::CMD_READ_HIGH) ? rom_word_in[15:8] : rom_word_in[7:0];
  wire logic tab_cmd = wr_tab && (sfr_in.wdata == nv_access_pkg::CMD_READ_LOW ||
    sfr_in.wdata == nv_access_pkg::CMD_READ_HIGH);

  wire logic [7:0] ctl_view = {5'h0, to_flag_reg, wd_sel_reg};
  wire logic [7:0] rdata_next =
    hit(sfr_in, nv_access_pkg::TABLE_READ_TRIGGER_ADDR) ? tab_reg :
    hit(sfr_in, nv_access_pkg::NV_WRITE_CONTROL_ADDR) ? ctl_view : nv_access_pkg::BYTE_RESET;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      key_reg <= nv_access_pkg::BYTE_RESET;
      lvr_off_reg <= 1'b0;
      tab_reg <= nv_access_pkg::BYTE_RESET;
      wd_sel_reg <= 2'h0;
    end
    else
    begin
      if (wr_key)
        key_reg <= sfr_in.wdata;
      // Only 37h turns the reset off
      if (wr_lvr)
        lvr_off_reg <= sfr_in.wdata == nv_access_pkg::LVR_OFF_VALUE;
      // Command fetch
      if (tab_cmd)
        tab_reg <= tab_fetch;
      if (wr_ctl)
        wd_sel_reg <= sfr_in.wdata[1:0];
    end
  end

  // Read data stands until the next read
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_reg <= nv_access_pkg::BYTE_RESET;
      rom_addr_reg <= 16'h0000;
    end
    else
    begin
      if (sfr_in.rd)
        rdata_reg <= rdata_next;
      rom_addr_reg <= table_pointer;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= nv_access_pkg::ST_IDLE;
      busy_reg <= 1'b0;
      prog_cnt_reg <= '0;
      wd_cnt_reg <= '0;
      to_flag_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      // Registered so the busy pin has no decode behind it
      busy_reg <= state_next == nv_access_pkg::ST_PROG;
      prog_cnt_reg <= prog_cnt_next;
      wd_cnt_reg <= wd_cnt_next;
      to_flag_reg <= to_flag_next;
    end
  end

  // Byte and address captured at launch
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      prog_addr_reg <= '0;
      prog_data_reg <= nv_access_pkg::BYTE_RESET;
    end
    else if (launch)
    begin
      prog_addr_reg <= nv_addr;
      prog_data_reg <= sfr_in.wdata;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (prog_done)
      mem[prog_addr_reg] <= prog_data_reg;
  end

  assign rom_addr_out = rom_addr_reg;
  assign sfr_rdata_out = rdata_reg;
  assign low_voltage_reset_off_out = lvr_off_reg;
  assign busy_out = busy_reg;

endmodule

// >>> rom_model.sv
// Program ROM model behind the table-read path.
// Assumes the word follows the address with no wait state.
`timescale 1ns/1ns
module rom_model (
  input wire logic [15:0] addr_in, // Table pointer
  output logic [15:0] word_out     // Word at pointer
);
  // Low byte mixes both halves so a dropped high byte shows
  assign word_out = {~addr_in[7:0], addr_in[7:0] ^ addr_in[15:8]};
endmodule

// >>> nv_access_monitor.sv
// Checker for the data EEPROM access unit, bound to its ports.
// Assumes the shortened programming time handed down by parameter.
`timescale 1ns/1ns
module nv_access_monitor #(
  parameter int PROG_CYC = 20
) (
  input wire logic clk_in, // Block clock
  input wire logic rst_n_in, // Async reset, low
  input wire nv_access_pkg::sfr_req_t sfr_in, // SFR access
  input wire logic [7:0] pointer_low_in, // Pointer low byte
  input wire logic [7:0] pointer_high_in, // Pointer high byte
  input wire logic [15:0] rom_addr_out, // ROM address
  input wire logic [7:0] sfr_rdata_out, // Read data
  input wire logic low_voltage_reset_off_out, // Reset-off level
  input wire logic busy_out // Programming busy
);
  logic [7:0] cnt_reg;
  wire wr_lvr = sfr_in.wr && sfr_in.addr == 9'h109;
  wire rd_zero = sfr_in.rd && sfr_in.addr != 9'h18c && sfr_in.addr != 9'h18d;
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      cnt_reg <= 8'h00;
    else
      cnt_reg <= busy_out ? cnt_reg + 8'h01 : 8'h00;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  rom_pointer_a: assert property ($past(rst_n_in) |->
    rom_addr_out == $past({pointer_high_in, pointer_low_in})) else $error("pointer lost");
  lvr_set_a: assert property (wr_lvr && sfr_in.wdata == 8'h37 |=> low_voltage_reset_off_out)
    else $error("lvr not off");
  lvr_clear_a: assert property (wr_lvr && sfr_in.wdata != 8'h37 |=> !low_voltage_reset_off_out)
    else $error("lvr stuck off");
  wo_read_a: assert property (rd_zero |=> sfr_rdata_out == 8'h00)
    else $error("write-only read not zero");
  ctl_spare_a: assert property (sfr_in.rd && sfr_in.addr == 9'h18d |=> sfr_rdata_out[7:3] == 5'h00)
    else $error("control spare bits set");
  rdata_hold_a: assert property (!sfr_in.rd |=> $stable(sfr_rdata_out))
    else $error("read data moved");
  prog_cause_a: assert property ($rose(busy_out) |->
    $past(sfr_in.wr && sfr_in.addr == 9'h18f)) else $error("busy without write");
  prog_time_a: assert property ($fell(busy_out) |-> cnt_reg == PROG_CYC)
    else $error("programming time wrong");
  cover property ($fell(busy_out));
  cover property (sfr_in.wr && sfr_in.addr == 9'h18c);
  cover property (low_voltage_reset_off_out);
endmodule
bind data_eeprom_access_unit nv_access_monitor #(.PROG_CYC(PROG_CYC)) mon (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .sfr_in(sfr_in), .pointer_low_in(pointer_low_in),
  .pointer_high_in(pointer_high_in), .rom_addr_out(rom_addr_out), .sfr_rdata_out(sfr_rdata_out),
  .low_voltage_reset_off_out(low_voltage_reset_off_out), .busy_out(busy_out));

// >>> tb.sv
// Bench for the data EEPROM access unit: SFR tasks and directed tests.
// Assumes shortened programming and watchdog counts.
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  nv_access_pkg::sfr_req_t req = '0;
  logic [7:0] lo = 8'h00, hi = 8'h00, rdata;
  logic [15:0] ra, rw;
  logic low_voltage_reset, busy;
  logic [8:0] wo[5] = '{9'h109, 9'h18d, 9'h18e, 9'h18f, 9'h1a0};
  int fails = 0, compares = 0;
  data_eeprom_access_unit #(.PROG_CYC(20), .WDOG_1(10), .WDOG_2(30), .WDOG_3(40)) dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .sfr_in(req), .pointer_low_in(lo),
    .pointer_high_in(hi), .rom_word_in(rw), .rom_addr_out(ra), .sfr_rdata_out(rdata),
    .low_voltage_reset_off_out(low_voltage_reset), .busy_out(busy));
  rom_model rom (.addr_in(ra), .word_out(rw));
  initial forever #10 clk_in = ~clk_in;
  task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d);
    @(negedge clk_in) req = {w, ~w, a, d};
    @(negedge clk_in) req = '0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    `CHK(rdata, e)
  endtask
  task automatic end_sim;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic prog(input logic [1:0] f, input logic [7:0] a, input logic [7:0] d);
    lo = a;
    acc(1'b1, 9'h18d, 8'h00);
    rd(9'h18d, 8'h00);
    acc(1'b1, 9'h18e, 8'he2);
    acc(1'b1, 9'h18d, {6'h00, f});
    acc(1'b1, 9'h109, 8'h37);
    `CHK(low_voltage_reset, 1'b1)
    acc(1'b1, 9'h18f, d);
    `CHK(busy, 1'b1)
    acc(1'b1, 9'h18f, ~d);
    for (int i = 0; i < 50 && busy === 1'b1; i++)
      @(negedge clk_in);
    if (busy !== 1'b0)
    begin
      fails++;
      end_sim;
    end
    // Rewriting the field must not touch the flag
    acc(1'b1, 9'h18d, {6'h00, f});
    rd(9'h18d, {5'h00, f == 2'b01, f});
    acc(1'b1, 9'h18c, 8'h01);
    rd(9'h18c, d);
    acc(1'b1, 9'h18c, 8'h02);
    rd(9'h18c, ~a);
    acc(1'b1, 9'h18e, 8'h00);
  endtask
  initial
  begin
    repeat (3) @(negedge clk_in);
    rst_n_in = 1'b1;
    foreach (wo[i])
      rd(wo[i], 8'h00);
    `CHK(low_voltage_reset, 1'b0)
    $display("test reset done");
    hi = 8'h03;
    lo = 8'h68;
    acc(1'b1, 9'h18c, 8'h01);
    rd(9'h18c, 8'h6b);
    acc(1'b1, 9'h18c, 8'h02);
    rd(9'h18c, 8'h97);
    acc(1'b1, 9'h18c, 8'h03);
    rd(9'h18c, 8'h97);
    hi = 8'h00;
    $display("test table read done");
    for (int f = 0; f < 4; f++)
      prog(2'(f), 8'(8'h20 + f), 8'(8'ha5 ^ f));
    $display("test write done");
    acc(1'b1, 9'h18e, 8'he3);
    acc(1'b1, 9'h109, 8'h00);
    `CHK(low_voltage_reset, 1'b0)
    lo = 8'h21;
    acc(1'b1, 9'h18f, 8'h5a);
    `CHK(busy, 1'b0)
    acc(1'b1, 9'h18c, 8'h01);
    rd(9'h18c, 8'h21);
    acc(1'b1, 9'h18e, 8'he2);
    acc(1'b1, 9'h18c, 8'h01);
    rd(9'h18c, 8'ha4);
    $display("test key done");
    end_sim;
  end
endmodule
